/* File: hw/mode_register_bank.sv */
// mode register bank with link-side command capture and read strobe
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module mode_register_bank #(
  // identity values are arbitrary
  parameter logic [7:0] MAKER_CODE = 8'h5a,
  parameter logic [7:0] REVISION_ONE = 8'h01,
  parameter logic [7:0] REVISION_TWO = 8'h02,
  parameter logic [7:0] GEOMETRY = 8'h18,
  parameter logic [2:0] REFRESH_RATE = 3'h3,
  parameter logic DEVICE_TYPE = 1'b0,
  parameter logic [7:0] PATTERN_A = 8'h55,
  parameter logic [7:0] PATTERN_B = 8'h33
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rstn,
  // link side, memory clock domain
  input wire logic memClk,
  input wire logic cke,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [7:0] regAddress,
  input wire logic [7:0] opcodeBits,
  // data and strobe pins
  output logic [7:0] dqOut,
  output logic dqOe,
  output logic dqsOut,
  output logic dqsOe,
  // device status
  output logic autoInitBusy,
  output logic calBusy
);
  // link reset release
  logic linkRstMeta_q, linkRstn_q;
  // link domain
  logic reqTgl_q, writeHold_q, ackMeta_q, ackSync_q, ackSeen_q, dqsOut_q;
  logic [7:0] addrHold_q, dqOut_q;
  mode_reg_pkg::opcode_t dataHold_q;
  logic [1:0] beat_q;
  logic linkBusy, linkAccept, ackEvent;
  // core domain
  logic reqMeta_q, reqSync_q, reqSeen_q, reqEvent, ackTgl_q, cmdWr_q;
  mode_reg_pkg::cmdStep_t step_q;
  logic [7:0] cmdAddr_q;
  mode_reg_pkg::opcode_t cmdData_q, rdData_q, answer;
  mode_reg_pkg::devState_t dev_q;
  logic [8:0] cnt_q;
  logic [1:0] impInfo_q;
  logic [3:0] slot;
  logic slotValid, resetHit, calHit, roWrite;

  mode_store_if st ();

  mode_store uStore (
    .clk(clk),
    .rstn(rstn),
    .st(st.store)
  );

  // link domain
  always_ff @(posedge memClk or negedge rstn) begin
    if (!rstn) begin
      linkRstMeta_q <= 1'b0;
      linkRstn_q <= 1'b0;
    end else begin
      linkRstMeta_q <= 1'b1;
      linkRstn_q <= linkRstMeta_q;
    end
  end

  always_ff @(posedge memClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      ackMeta_q <= 1'b0;
      ackSync_q <= 1'b0;
      ackSeen_q <= 1'b0;
    end else begin
      ackMeta_q <= ackTgl_q;
      ackSync_q <= ackMeta_q;
      ackSeen_q <= ackSync_q;
    end
  end

  assign ackEvent = ackSync_q ^ ackSeen_q;
  assign linkBusy = reqTgl_q ^ ackSeen_q;
  assign linkAccept = cke && cmdValid && !linkBusy;

  // command capture, one command in flight
  always_ff @(posedge memClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      reqTgl_q <= 1'b0;
      addrHold_q <= 8'h00;
      dataHold_q <= `OPCODE_RESET;
      writeHold_q <= 1'b0;
    end else if (linkAccept) begin
      reqTgl_q <= ~reqTgl_q;
      addrHold_q <= regAddress;
      dataHold_q <= opcodeBits;
      writeHold_q <= cmdWrite;
    end
  end

  // read burst: every read answer that arrives while cke is high strobes, whatever the address
  always_ff @(posedge memClk or negedge linkRstn_q) begin
    if (!linkRstn_q) begin
      beat_q <= 2'h0;
      dqOut_q <= 8'h00;
      dqsOut_q <= 1'b0;
    end else if (!cke) begin
      beat_q <= 2'h0;
      dqsOut_q <= 1'b0;
    end else if (ackEvent && !writeHold_q) begin
      beat_q <= `READ_BEATS;
      dqOut_q <= rdData_q;
      dqsOut_q <= 1'b1;
    end else if (beat_q != 2'h0) begin
      beat_q <= beat_q - 2'h1;
      dqsOut_q <= 1'b0;
    end
  end

  assign dqOut = dqOut_q;
  assign dqsOut = dqsOut_q;
  assign dqOe = cke && (beat_q != 2'h0);
  assign dqsOe = cke && (beat_q != 2'h0);

  // core domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reqMeta_q <= 1'b0;
      reqSync_q <= 1'b0;
      reqSeen_q <= 1'b0;
    end else begin
      reqMeta_q <= reqTgl_q;
      reqSync_q <= reqMeta_q;
      reqSeen_q <= reqSync_q;
    end
  end

  assign reqEvent = reqSync_q ^ reqSeen_q;

  // write-only slots; all others except the reset trigger take no write
  always_comb begin
    slotValid = 1'b1;
    slot = cmdAddr_q[3:0];
    if (cmdAddr_q == `ADDR_FEATURE_ONE || cmdAddr_q == `ADDR_FEATURE_TWO
        || cmdAddr_q == `ADDR_IO_CONFIG_ONE || cmdAddr_q == `ADDR_TEST_MODE
        || cmdAddr_q == `ADDR_IO_CALIBRATION) begin
      slot = cmdAddr_q[3:0];
    end else if (cmdAddr_q == `ADDR_SR_BANK_MASK) begin
      slot = `SLOT_SR_BANK_MASK;
    end else if (cmdAddr_q == `ADDR_SR_SEGMENT_MASK) begin
      slot = `SLOT_SR_SEGMENT_MASK;
    end else begin
      slotValid = 1'b0;
    end
  end

  assign resetHit = (step_q == mode_reg_pkg::stepLook) && cmdWr_q
    && cmdAddr_q == `ADDR_RESET_TRIGGER;
  assign calHit = (step_q == mode_reg_pkg::stepLook) && cmdWr_q
    && cmdAddr_q == `ADDR_IO_CALIBRATION;
  assign roWrite = (step_q == mode_reg_pkg::stepLook) && cmdWr_q && !slotValid
    && cmdAddr_q != `ADDR_RESET_TRIGGER;

  assign st.we = (step_q == mode_reg_pkg::stepLook) && cmdWr_q && slotValid;
  assign st.wSlot = slot;
  assign st.wData = cmdData_q;
  assign st.rSlot = slot;

  // read answer; reserved bits zero
  always_comb begin
    answer = 8'h00;
    if (cmdAddr_q == `ADDR_DEVICE_INFO) begin
      answer[`POS_AUTO_INIT] = autoInitBusy;
      answer[`POS_DEVICE_TYPE] = DEVICE_TYPE;
      answer[`POS_IMPEDANCE_LO +: 2] = impInfo_q;
    end else if (cmdAddr_q == `ADDR_REFRESH_STATUS) begin
      answer[`POS_TEMP_UPDATE] = 1'b0;
      answer[2:0] = REFRESH_RATE;
    end else if (cmdAddr_q == `ADDR_MAKER_CODE) begin
      answer = MAKER_CODE;
    end else if (cmdAddr_q == `ADDR_REVISION_ONE) begin
      answer = REVISION_ONE;
    end else if (cmdAddr_q == `ADDR_REVISION_TWO) begin
      answer = REVISION_TWO;
    end else if (cmdAddr_q == `ADDR_GEOMETRY) begin
      answer = GEOMETRY;
    end else if (cmdAddr_q == `ADDR_PATTERN_A) begin
      answer = PATTERN_A;
    end else if (cmdAddr_q == `ADDR_PATTERN_B) begin
      answer = PATTERN_B;
    end else if (slotValid) begin
      answer = st.rData;
    end
  end

  // command sequencing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_q <= mode_reg_pkg::stepIdle;
      cmdAddr_q <= 8'h00;
      cmdData_q <= `OPCODE_RESET;
      cmdWr_q <= 1'b0;
      rdData_q <= `OPCODE_RESET;
      ackTgl_q <= 1'b0;
    end else begin
      case (step_q)
        mode_reg_pkg::stepIdle: begin
          if (reqEvent) begin
            cmdAddr_q <= addrHold_q;
            cmdData_q <= dataHold_q;
            cmdWr_q <= writeHold_q;
            step_q <= mode_reg_pkg::stepLook;
          end
        end
        mode_reg_pkg::stepLook: begin
          step_q <= mode_reg_pkg::stepAnswer;
        end
        default: begin
          if (!cmdWr_q) begin
            rdData_q <= answer;
          end
          ackTgl_q <= ~ackTgl_q;
          step_q <= mode_reg_pkg::stepIdle;
        end
      endcase
    end
  end

  // auto init and calibration
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dev_q <= mode_reg_pkg::devInit;
      cnt_q <= 9'(`AUTO_INIT_CYCLES);
      impInfo_q <= `IMPEDANCE_INFO_RESET;
    end else if (resetHit) begin
      dev_q <= mode_reg_pkg::devInit;
      cnt_q <= 9'(`AUTO_INIT_CYCLES);
      impInfo_q <= `IMPEDANCE_INFO_RESET;
    end else begin
      case (dev_q)
        mode_reg_pkg::devInit: begin
          if (cnt_q == 9'h001) begin
            dev_q <= mode_reg_pkg::devIdle;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
        mode_reg_pkg::devIdle: begin
          if (calHit) begin
            dev_q <= mode_reg_pkg::devCal;
            cnt_q <= 9'(`CAL_CYCLES);
          end
        end
        default: begin
          if (cnt_q == 9'h001) begin
            dev_q <= mode_reg_pkg::devIdle;
            impInfo_q <= `IMPEDANCE_INFO_DONE;
          end else begin
            cnt_q <= cnt_q - 9'h001;
          end
        end
      endcase
    end
  end

  assign autoInitBusy = (dev_q == mode_reg_pkg::devInit);
  assign calBusy = (dev_q == mode_reg_pkg::devCal);

  // checks
  sequence readStart;
    ackEvent && !writeHold_q && cke;
  endsequence

  sequence strobePair;
    (dqsOe && dqsOut) ##1 ((dqsOe && !dqsOut) || !cke);
  endsequence

  hiz_while_low_a: assert property (
    @(posedge memClk) disable iff (!linkRstn_q) !cke |-> !dqOe && !dqsOe)
    else $error("pins driven while clock enable low");
  read_strobe_a: assert property (
    @(posedge memClk) disable iff (!linkRstn_q) (readStart ##1 cke) |-> strobePair)
    else $error("read answer without strobe pair");
  cmd_answered_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (reqEvent && step_q == mode_reg_pkg::stepIdle) |-> ##3 $changed(ackTgl_q))
    else $error("command not answered in three cycles");
  reset_starts_init_a: assert property (
    @(posedge clk) disable iff (!rstn) resetHit |=> autoInitBusy[*8])
    else $error("reset write did not start auto init");
  cal_starts_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (calHit && dev_q == mode_reg_pkg::devIdle) |=> calBusy)
    else $error("calibration write did not start calibration");
  init_done_a: assert property (
    @(posedge clk) disable iff (!rstn) $fell(autoInitBusy) |-> $past(cnt_q) == 9'h001)
    else $error("auto init flag cleared early");
  ro_write_ignored_a: assert property (
    @(posedge clk) disable iff (!rstn)
    roWrite |-> !st.we ##1 ($stable(rdData_q) && $stable(impInfo_q)))
    else $error("read-only write changed state");

  reserved_zero_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (step_q == mode_reg_pkg::stepAnswer && !cmdWr_q && cmdAddr_q == `ADDR_DEVICE_INFO)
    |=> rdData_q[7:5] == 3'h0 && !rdData_q[2])
    else $error("reserved bits read nonzero");

  pattern_a_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (step_q == mode_reg_pkg::stepAnswer && !cmdWr_q && cmdAddr_q == `ADDR_PATTERN_A)
    |=> rdData_q == PATTERN_A)
    else $error("pattern a wrong");

  pattern_b_a: assert property (
    @(posedge clk) disable iff (!rstn)
    (step_q == mode_reg_pkg::stepAnswer && !cmdWr_q && cmdAddr_q == `ADDR_PATTERN_B)
    |=> rdData_q == PATTERN_B)
    else $error("pattern b wrong");
endmodule : mode_register_bank
`default_nettype wire

/* File: hw/mode_reg_defines.svh */
// register offsets, field positions, reset values and timing counts
`ifndef MODE_REG_DEFINES_SVH
`define MODE_REG_DEFINES_SVH

// register addresses
`define ADDR_DEVICE_INFO 8'h00
`define ADDR_FEATURE_ONE 8'h01
`define ADDR_FEATURE_TWO 8'h02
`define ADDR_IO_CONFIG_ONE 8'h03
`define ADDR_REFRESH_STATUS 8'h04
`define ADDR_MAKER_CODE 8'h05
`define ADDR_REVISION_ONE 8'h06
`define ADDR_REVISION_TWO 8'h07
`define ADDR_GEOMETRY 8'h08
`define ADDR_TEST_MODE 8'h09
`define ADDR_IO_CALIBRATION 8'h0a
`define ADDR_SR_BANK_MASK 8'h10
`define ADDR_SR_SEGMENT_MASK 8'h11
`define ADDR_PATTERN_A 8'h20
`define ADDR_PATTERN_B 8'h28
`define ADDR_RESET_TRIGGER 8'h3f

// store slots of the write-only registers
`define SLOT_SR_BANK_MASK 4'h4
`define SLOT_SR_SEGMENT_MASK 4'h5

// device info and refresh status field positions
`define POS_AUTO_INIT 0
`define POS_DEVICE_TYPE 1
`define POS_IMPEDANCE_LO 3
`define POS_TEMP_UPDATE 7

// reset values and calibration done value
`define IMPEDANCE_INFO_RESET 2'h0
`define IMPEDANCE_INFO_DONE 2'h3
`define OPCODE_RESET 8'h00

// timing: clock period, auto init longest time, calibration least time
`define CLK_PERIOD_NS 25
`define AUTO_INIT_MAX_NS 10000
`define AUTO_INIT_CYCLES (`AUTO_INIT_MAX_NS / `CLK_PERIOD_NS)
`define CAL_MIN_NS 1000
`define CAL_CYCLES ((`CAL_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_BEATS 2'h2

`endif

/* File: hw/mode_reg_pkg.sv */
// types shared by the mode register bank
package mode_reg_pkg;
  typedef logic [7:0] opcode_t;
  typedef enum logic [1:0] {devInit, devIdle, devCal} devState_t;
  typedef enum logic [1:0] {stepIdle, stepLook, stepAnswer} cmdStep_t;
endpackage : mode_reg_pkg

/* File: hw/mode_store_if.sv */
// carrier between the bank core and its register store
`timescale 1ns/1ps
`default_nettype none
interface mode_store_if;
  logic we;
  logic [3:0] wSlot;
  mode_reg_pkg::opcode_t wData;
  logic [3:0] rSlot;
  mode_reg_pkg::opcode_t rData;
  modport core (output we, output wSlot, output wData, output rSlot, input rData);
  modport store (input we, input wSlot, input wData, input rSlot, output rData);
endinterface : mode_store_if
`default_nettype wire

/* File: hw/mode_store.sv */
// sixteen-entry store for written opcode bytes, registered read
`timescale 1ns/1ps
`default_nettype none
`include "mode_reg_defines.svh"
module mode_store (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // access
  mode_store_if.store st
);
  mode_reg_pkg::opcode_t mem_q [16];

  genvar i;
  generate
    for (i = 0; i < 16; i++) begin : gEntry
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          mem_q[i] <= `OPCODE_RESET;
        end else if (st.we && st.wSlot == 4'(i)) begin
          mem_q[i] <= st.wData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st.rData <= `OPCODE_RESET;
    end else begin
      st.rData <= mem_q[st.rSlot];
    end
  end
endmodule : mode_store
`default_nettype wire

/* File: verification/ctrl_model.sv */
// controller model issuing mode register commands on the link clock
`timescale 1ns/1ps
`default_nettype none
module ctrl_model (
  // link clock and command pins
  output logic memClk,
  output logic cke,
  output logic cmdValid,
  output logic cmdWrite,
  output logic [7:0] regAddress,
  output logic [7:0] opcodeBits
);
  initial begin
    memClk = 1'b0;
    forever #6 memClk = ~memClk;
  end
  initial begin
    cke = 1'b0;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    regAddress = 8'h00;
    opcodeBits = 8'h00;
  end
  // reserved register space
  function automatic logic reservedAddr(input logic [7:0] a);
    return (a >= 8'h0b && a <= 8'h0f) || (a >= 8'h12 && a <= 8'h1f) ||
      (a >= 8'h30 && a <= 8'h3e) || (a >= 8'h40 && a <= 8'h7e);
  endfunction : reservedAddr
  task automatic setCke(input logic v);
    @(posedge memClk);
    cke <= v;
  endtask : setCke
  task automatic send(input logic wr, input logic [7:0] a, input logic [7:0] d);
    if (wr && reservedAddr(a)) return;
    @(posedge memClk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    regAddress <= a;
    opcodeBits <= (a == 8'h02 || a == 8'h03) ? {4'h0, d[3:0]} : d;
    @(posedge memClk);
    cmdValid <= 1'b0;
    regAddress <= ~a;
    opcodeBits <= ~d;
  endtask : send
endmodule : ctrl_model
`default_nettype wire

/* File: verification/testbench.sv */
// self-checking bench for the mode register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rstn, memClk, cke, cmdValid, cmdWrite;
  logic dqOe, dqsOut, dqsOe, autoInitBusy, calBusy;
  logic [7:0] regAddress, opcodeBits, dqOut;
  int n_fail, compares;
  logic [7:0] roA [8] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h20, 8'h28};
  logic [7:0] roV [8] = '{8'h00, 8'h03, 8'h5a, 8'h01, 8'h02, 8'h18, 8'h55, 8'h33};
  logic [7:0] badA [8] = '{8'h0b, 8'h21, 8'h30, 8'h7f, 8'h80, 8'hbf, 8'hff, 8'h3f};
  logic [7:0] woA [6] = '{8'h01, 8'h02, 8'h03, 8'h09, 8'h10, 8'h11};
  mode_register_bank u_dut (
    .clk(clk),
    .rstn(rstn),
    .memClk(memClk),
    .cke(cke),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .regAddress(regAddress),
    .opcodeBits(opcodeBits),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .dqsOut(dqsOut),
    .dqsOe(dqsOe),
    .autoInitBusy(autoInitBusy),
    .calBusy(calBusy)
  );
  ctrl_model u_ctrl (
    .memClk(memClk),
    .cke(cke),
    .cmdValid(cmdValid),
    .cmdWrite(cmdWrite),
    .regAddress(regAddress),
    .opcodeBits(opcodeBits)
  );
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test;
    $display("compares %0d failures %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check
  task automatic checkBit(input logic got, input logic exp, input string what);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %b", $time, what, got);
    end
  endtask : checkBit
  task automatic timeout(input string what);
    n_fail++;
    $display("CHECK FAILED %0t wait for %s ran out", $time, what);
    finish_test();
  endtask : timeout
  // waits for the burst, checks strobe shape and length
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    int i;
    u_ctrl.send(1'b0, a, 8'h00);
    for (i = 0; i < 40; i++) begin
      @(negedge memClk);
      if (dqOe === 1'b1) break;
    end
    if (i == 40) timeout("burst");
    d = dqOut;
    checkBit(dqsOut & dqsOe, 1'b1, "strobe high");
    @(negedge memClk);
    checkBit(dqsOut, 1'b0, "strobe low");
    @(negedge memClk);
    checkBit(dqOe | dqsOe, 1'b0, "burst end");
  endtask : readReg
  // which 0 watches autoInitBusy, 1 calBusy
  task automatic waitFlag(input int which, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++) begin
      @(negedge clk);
      if ((which ? calBusy : autoInitBusy) === v) return;
    end
    timeout("status");
  endtask : waitFlag
  function automatic logic [7:0] infoExp(input logic busy, input logic calDone);
    return {3'h0, calDone ? 2'h3 : 2'h0, 1'b0, 1'b0, busy};
  endfunction : infoExp
  // write-only read back: last byte written, reserved bits zero
  function automatic logic [7:0] woExp(input logic [7:0] a, input logic [7:0] v);
    return (a == 8'h02 || a == 8'h03) ? {4'h0, v[3:0]} : v;
  endfunction : woExp
  initial begin
    logic [7:0] d;
    int n, k, j;
    n_fail = 0;
    compares = 0;
    rstn = 1'b0;
    void'($urandom(32'h52de));
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge memClk);
    u_ctrl.setCke(1'b1);
    readReg(8'h00, d);
    check(d, infoExp(1'b1, 1'b0), "init info");
    waitFlag(0, 1'b0, 420, n);
    u_ctrl.send(1'b1, 8'hc0, 8'($urandom));
    repeat (14) @(posedge memClk);
    for (k = 0; k < 16; k++) begin
      j = (k < 8) ? k : $urandom_range(7);
      u_ctrl.send(1'b1, roA[j], 8'($urandom));
      repeat (14) @(posedge memClk);
      readReg(roA[j], d);
      check(d, roV[j], "ro value");
    end
    for (k = 0; k < 6; k++) begin
      j = $urandom;
      u_ctrl.send(1'b1, woA[k], 8'(j));
      repeat (14) @(posedge memClk);
      readReg(woA[k], d);
      check(d, woExp(woA[k], 8'(j)), "wo value");
    end
    for (k = 0; k < 8; k++) readReg(badA[k], d);
    u_ctrl.send(1'b1, 8'h0a, 8'hff);
    waitFlag(1, 1'b1, 40, n);
    waitFlag(1, 1'b0, 60, n);
    checkBit(n >= 38 && n <= 41, 1'b1, "cal length");
    readReg(8'h00, d);
    check(d, infoExp(1'b0, 1'b1), "cal info");
    u_ctrl.send(1'b1, 8'h3f, 8'h00);
    waitFlag(0, 1'b1, 40, n);
    repeat (14) @(posedge memClk);
    readReg(8'h00, d);
    check(d, infoExp(1'b1, 1'b0), "reset info");
    waitFlag(0, 1'b0, 420, n);
    checkBit(n >= 370, 1'b1, "init length");
    u_ctrl.send(1'b0, 8'h20, 8'h00);
    for (k = 0; k < 40 && dqOe !== 1'b1; k++) @(negedge memClk);
    if (k == 40) timeout("burst");
    u_ctrl.setCke(1'b0);
    @(negedge memClk);
    checkBit(dqOe | dqsOe, 1'b0, "cke cut");
    u_ctrl.send(1'b0, 8'h28, 8'h00);
    u_ctrl.setCke(1'b1);
    for (k = 0; k < 30; k++) begin
      @(negedge memClk);
      if (dqOe !== 1'b0 || dqsOe !== 1'b0) break;
    end
    checkBit(dqOe | dqsOe, 1'b0, "cke low quiet");
    readReg(8'h28, d);
    check(d, 8'h33, "after cke");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
